// ==== dcr_pkg.sv ====
package dcr_pkg;

  // access port widths and channel count
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 2;

  // chip configuration area
  localparam logic [ADDR_W-1:0] ADDR_PORT_SETUP   = 13'h000;
  localparam logic [ADDR_W-1:0] ADDR_PART_ID      = 13'h001;
  localparam logic [ADDR_W-1:0] ADDR_SPEED_GRADE  = 13'h002;
  // channel index and transfer area
  localparam logic [ADDR_W-1:0] ADDR_CHAN_SELECT  = 13'h005;
  localparam logic [ADDR_W-1:0] ADDR_SHADOW_UPD   = 13'h0ff;
  // converter function area
  localparam logic [ADDR_W-1:0] ADDR_POWER_STATE  = 13'h008;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_COND   = 13'h009;

  // reset values, bit 7 is the msb
  localparam logic [DATA_W-1:0] RST_PORT_SETUP  = 8'h18;
  localparam logic [DATA_W-1:0] RST_CHAN_SELECT = 8'h03;
  localparam logic [DATA_W-1:0] RST_POWER_STATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_CLOCK_COND  = 8'h01;
  localparam logic [DATA_W-1:0] RST_SHADOW_UPD  = 8'h00;

  // port setup fields, mirrored nibbles
  localparam int PS_LSB_HI  = 6;
  localparam int PS_SRST_HI = 5;
  localparam int PS_ONE_HI  = 4;
  localparam int PS_ONE_LO  = 3;
  localparam int PS_SRST_LO = 2;
  localparam int PS_LSB_LO  = 1;

  // channel select fields
  localparam int CS_CHAN_A = 0;
  localparam int CS_CHAN_B = 1;

  // writable bit masks
  localparam logic [DATA_W-1:0] MASK_CHAN_SELECT = 8'h03;
  localparam logic [DATA_W-1:0] MASK_POWER_STATE = 8'h23;
  localparam logic [DATA_W-1:0] MASK_CLOCK_COND  = 8'h01;
  localparam logic [DATA_W-1:0] MASK_SHADOW_UPD  = 8'h01;

  // field positions
  localparam int PW_PIN_FN  = 5;
  localparam int CC_DCS     = 0;
  localparam int SU_XFER    = 0;
  localparam int GR_LSB     = 4;
  localparam int GR_W       = 3;

  // request from the serial engine
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcr_req_type;

  // applied configuration toward the converter core
  typedef struct packed {
    logic       lsb_first;
    logic [1:0] pwr_mode_a;
    logic       pin_fn_a;
    logic [1:0] pwr_mode_b;
    logic       pin_fn_b;
    logic       dcs_en;
  } dcr_cfg_type;

endpackage

// ==== dcr_regmap.sv ====
// Contract
// - map: config 0x00-0x02, index 0x05/0xFF, functions from 0x08.
// - every register location is eight bits wide.
// - default values read with bit 7 as most significant bit.
// - channel select resets to 0x03, both low bits set.
// - default channel select sends next local write to both channels.
// - reset loads configuration registers with their default values.
// - local registers have one copy per channel, chosen by select bits.
// - both select bits set makes a local write update both copies.
// - local read with both select bits set returns the channel A copy.
// - global registers have one copy, independent of channel select.
module dcr_regmap #(
  parameter logic [7:0] PART_ID     = 8'h5a, // arbitrary value
  parameter logic [2:0] SPEED_GRADE = 3'h5
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // register access from the serial engine
  input  wire dcr_pkg::dcr_req_type        req,
  output logic     [dcr_pkg::DATA_W-1:0]   rdata,
  output logic                             rvalid,
  // applied configuration
  output dcr_pkg::dcr_cfg_type             cfg
);

  // state
  logic                       lsb_first_ff, nxt_lsb_first;
  logic                       soft_ff,      nxt_soft;
  logic [dcr_pkg::DATA_W-1:0] chsel_ff,     nxt_chsel;
  logic [dcr_pkg::DATA_W-1:0] pwr_ff  [dcr_pkg::NUM_CH];
  logic [dcr_pkg::DATA_W-1:0] nxt_pwr [dcr_pkg::NUM_CH];
  logic [dcr_pkg::DATA_W-1:0] clk_ff,       nxt_clk;
  logic [dcr_pkg::DATA_W-1:0] xfer_ff,      nxt_xfer;
  dcr_pkg::dcr_cfg_type       act_ff,       nxt_act;
  logic [dcr_pkg::DATA_W-1:0] rdata_ff,     nxt_rdata;
  logic                       rvalid_ff,    nxt_rvalid;

  // applied set after reset mirrors the register defaults
  localparam dcr_pkg::dcr_cfg_type ACT_RST = '{
    lsb_first:  dcr_pkg::RST_PORT_SETUP[dcr_pkg::PS_LSB_HI],
    pwr_mode_a: dcr_pkg::RST_POWER_STATE[1:0],
    pin_fn_a:   dcr_pkg::RST_POWER_STATE[dcr_pkg::PW_PIN_FN],
    pwr_mode_b: dcr_pkg::RST_POWER_STATE[1:0],
    pin_fn_b:   dcr_pkg::RST_POWER_STATE[dcr_pkg::PW_PIN_FN],
    dcs_en:     dcr_pkg::RST_CLOCK_COND[dcr_pkg::CC_DCS]
  };

  // address hit, shared by the write and read paths
  function automatic logic hit(input logic [dcr_pkg::ADDR_W-1:0] a,
                               input logic [dcr_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // read value of the mirrored port setup register
  function automatic logic [7:0] setup_word(input logic lsb,
                                            input logic srst);
    setup_word = '0;
    setup_word[dcr_pkg::PS_LSB_HI]  = lsb;
    setup_word[dcr_pkg::PS_LSB_LO]  = lsb;
    setup_word[dcr_pkg::PS_SRST_HI] = srst;
    setup_word[dcr_pkg::PS_SRST_LO] = srst;
    setup_word[dcr_pkg::PS_ONE_HI]  = 1'b1;
    setup_word[dcr_pkg::PS_ONE_LO]  = 1'b1;
  endfunction

  // next-state logic; soft reset outranks any same-cycle write
  always_comb begin
    nxt_lsb_first = lsb_first_ff;
    nxt_soft      = 1'b0;
    nxt_chsel     = chsel_ff;
    nxt_clk       = clk_ff;
    nxt_xfer      = dcr_pkg::RST_SHADOW_UPD; // transfer self-clears
    nxt_act       = act_ff;
    for (int c = 0; c < dcr_pkg::NUM_CH; c++) begin
      nxt_pwr[c] = pwr_ff[c];
    end
    if (soft_ff) begin
      // soft reset reloads every register default; the applied set keeps its value
      nxt_lsb_first = dcr_pkg::RST_PORT_SETUP[dcr_pkg::PS_LSB_HI];
      nxt_chsel     = dcr_pkg::RST_CHAN_SELECT;
      nxt_clk       = dcr_pkg::RST_CLOCK_COND;
      for (int c = 0; c < dcr_pkg::NUM_CH; c++) begin
        nxt_pwr[c] = dcr_pkg::RST_POWER_STATE;
      end
    end else if (req.wr) begin
      // decode of the three areas
      if (hit(req.addr, dcr_pkg::ADDR_PORT_SETUP)) begin
        // either mirror copy sets the field, so shift order never matters
        nxt_lsb_first = req.wdata[dcr_pkg::PS_LSB_HI] |
                        req.wdata[dcr_pkg::PS_LSB_LO];
        nxt_soft      = req.wdata[dcr_pkg::PS_SRST_HI] |
                        req.wdata[dcr_pkg::PS_SRST_LO];
      end
      if (hit(req.addr, dcr_pkg::ADDR_CHAN_SELECT)) begin
        nxt_chsel = req.wdata & dcr_pkg::MASK_CHAN_SELECT;
      end
      if (hit(req.addr, dcr_pkg::ADDR_CLOCK_COND)) begin
        // single global copy, select bits ignored
        nxt_clk = req.wdata & dcr_pkg::MASK_CLOCK_COND;
      end
      if (hit(req.addr, dcr_pkg::ADDR_SHADOW_UPD)) begin
        nxt_xfer = req.wdata & dcr_pkg::MASK_SHADOW_UPD;
      end
      if (hit(req.addr, dcr_pkg::ADDR_POWER_STATE)) begin
        // one copy per channel, each gated by its select bit
        for (int c = 0; c < dcr_pkg::NUM_CH; c++) begin
          if (chsel_ff[c]) begin
            nxt_pwr[c] = req.wdata & dcr_pkg::MASK_POWER_STATE;
          end
        end
      end
    end
    // shadow transfer moves master values into the applied set
    if (xfer_ff[dcr_pkg::SU_XFER]) begin
      nxt_act.lsb_first  = lsb_first_ff;
      nxt_act.pwr_mode_a = pwr_ff[0][1:0];
      nxt_act.pin_fn_a   = pwr_ff[0][dcr_pkg::PW_PIN_FN];
      nxt_act.pwr_mode_b = pwr_ff[1][1:0];
      nxt_act.pin_fn_b   = pwr_ff[1][dcr_pkg::PW_PIN_FN];
      nxt_act.dcs_en     = clk_ff[dcr_pkg::CC_DCS];
    end
  end

  // read path: one cycle latency, unmapped reads return zero
  always_comb begin
    nxt_rvalid = req.rd;
    nxt_rdata  = rdata_ff;
    if (req.rd) begin
      nxt_rdata = '0;
      if (hit(req.addr, dcr_pkg::ADDR_PORT_SETUP)) begin
        nxt_rdata = setup_word(lsb_first_ff, soft_ff);
      end
      if (hit(req.addr, dcr_pkg::ADDR_PART_ID)) begin
        nxt_rdata = PART_ID;
      end
      if (hit(req.addr, dcr_pkg::ADDR_SPEED_GRADE)) begin
        nxt_rdata[dcr_pkg::GR_LSB +: dcr_pkg::GR_W] = SPEED_GRADE;
      end
      if (hit(req.addr, dcr_pkg::ADDR_CHAN_SELECT)) begin
        nxt_rdata = chsel_ff;
      end
      if (hit(req.addr, dcr_pkg::ADDR_CLOCK_COND)) begin
        nxt_rdata = clk_ff;
      end
      if (hit(req.addr, dcr_pkg::ADDR_SHADOW_UPD)) begin
        nxt_rdata = xfer_ff;
      end
      if (hit(req.addr, dcr_pkg::ADDR_POWER_STATE)) begin
        // channel A wins when both are selected
        if (chsel_ff[dcr_pkg::CS_CHAN_A]) begin
          nxt_rdata = pwr_ff[0];
        end else if (chsel_ff[dcr_pkg::CS_CHAN_B]) begin
          nxt_rdata = pwr_ff[1];
        end
      end
    end
  end

  // registers; every location is one byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // defaults, msb first
      lsb_first_ff <= dcr_pkg::RST_PORT_SETUP[dcr_pkg::PS_LSB_HI];
      soft_ff      <= 1'b0;
      chsel_ff     <= dcr_pkg::RST_CHAN_SELECT;
      clk_ff       <= dcr_pkg::RST_CLOCK_COND;
      xfer_ff      <= dcr_pkg::RST_SHADOW_UPD;
      for (int c = 0; c < dcr_pkg::NUM_CH; c++) begin
        pwr_ff[c] <= dcr_pkg::RST_POWER_STATE;
      end
      act_ff       <= ACT_RST;
      rdata_ff     <= '0;
      rvalid_ff    <= 1'b0;
    end else begin
      lsb_first_ff <= nxt_lsb_first;
      soft_ff      <= nxt_soft;
      chsel_ff     <= nxt_chsel;
      clk_ff       <= nxt_clk;
      xfer_ff      <= nxt_xfer;
      for (int c = 0; c < dcr_pkg::NUM_CH; c++) begin
        pwr_ff[c] <= nxt_pwr[c];
      end
      act_ff       <= nxt_act;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
    end
  end

  // outputs straight from flip-flops
  assign rdata  = rdata_ff;
  assign rvalid = rvalid_ff;
  assign cfg    = act_ff;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic pwr_wr;
  logic pwr_rd;
  assign pwr_wr = req.wr && !soft_ff &&
                  hit(req.addr, dcr_pkg::ADDR_POWER_STATE);
  assign pwr_rd = req.rd && hit(req.addr, dcr_pkg::ADDR_POWER_STATE);

  logic xfer_wr;
  assign xfer_wr = req.wr && !soft_ff &&
                   hit(req.addr, dcr_pkg::ADDR_SHADOW_UPD) &&
                   req.wdata[dcr_pkg::SU_XFER];

  // a transfer right behind another keeps the bit up, so wait for a gap
  sequence xfer_req_s;
    xfer_wr ##1 !xfer_wr;
  endsequence

  sequence xfer_done_s;
    xfer_ff[dcr_pkg::SU_XFER] ##1 !xfer_ff[dcr_pkg::SU_XFER];
  endsequence

  sel_default_a: assert property (
    soft_ff |=> chsel_ff == dcr_pkg::RST_CHAN_SELECT)
    else $error("channel select not back to default after soft reset");

  wr_both_a: assert property (
    pwr_wr && chsel_ff[1:0] == 2'h3 |=>
      pwr_ff[0] == pwr_ff[1] &&
      pwr_ff[1] == ($past(req.wdata) & dcr_pkg::MASK_POWER_STATE))
    else $error("write with both channels selected missed a copy");

  wr_chan_b_a: assert property (
    pwr_wr && chsel_ff[1:0] == 2'h2 |=> $stable(pwr_ff[0]))
    else $error("channel A copy changed by a channel B write");

  rd_both_a: assert property (
    pwr_rd && chsel_ff[1:0] == 2'h3 |=> rdata == $past(pwr_ff[0]))
    else $error("read with both channels selected not channel A");

  rd_answer_a: assert property (
    req.rd |=> rvalid ##1 (rvalid == $past(req.rd)))
    else $error("read answer not one cycle after request");

  glob_clock_a: assert property (
    req.wr && !soft_ff && hit(req.addr, dcr_pkg::ADDR_CLOCK_COND) |=>
      clk_ff[dcr_pkg::CC_DCS] == $past(req.wdata[dcr_pkg::CC_DCS]))
    else $error("global register depends on channel select");

  xfer_apply_a: assert property (
    xfer_req_s |-> xfer_done_s ##0
      (cfg.dcs_en == $past(clk_ff[dcr_pkg::CC_DCS]) &&
       cfg.pwr_mode_b == $past(pwr_ff[1][1:0])))
    else $error("shadow transfer did not apply master values");

  soft_load_a: assert property (
    soft_ff |=> clk_ff == dcr_pkg::RST_CLOCK_COND &&
                pwr_ff[0] == dcr_pkg::RST_POWER_STATE &&
                pwr_ff[1] == dcr_pkg::RST_POWER_STATE && !soft_ff)
    else $error("soft reset did not load defaults");

  setup_read_a: assert property (
    req.rd && hit(req.addr, dcr_pkg::ADDR_PORT_SETUP) && !lsb_first_ff &&
    !soft_ff |=> rdata == dcr_pkg::RST_PORT_SETUP)
    else $error("port setup reads wrong value");

  // reads that hit no mapped location
  logic open_rd;
  assign open_rd = req.rd &&
                   !hit(req.addr, dcr_pkg::ADDR_PORT_SETUP) &&
                   !hit(req.addr, dcr_pkg::ADDR_PART_ID) &&
                   !hit(req.addr, dcr_pkg::ADDR_SPEED_GRADE) &&
                   !hit(req.addr, dcr_pkg::ADDR_CHAN_SELECT) &&
                   !hit(req.addr, dcr_pkg::ADDR_SHADOW_UPD) &&
                   !hit(req.addr, dcr_pkg::ADDR_POWER_STATE) &&
                   !hit(req.addr, dcr_pkg::ADDR_CLOCK_COND);

  open_read_a: assert property (
    open_rd |=> rdata == '0)
    else $error("open location did not read as zero");

  part_id_a: assert property (
    req.rd && hit(req.addr, dcr_pkg::ADDR_PART_ID) |=> rdata == PART_ID)
    else $error("part identifier reads wrong value");

  grade_read_a: assert property (
    req.rd && hit(req.addr, dcr_pkg::ADDR_SPEED_GRADE) |=>
      rdata[dcr_pkg::GR_LSB +: dcr_pkg::GR_W] == SPEED_GRADE)
    else $error("speed grade reads wrong value");

  sel_write_a: assert property (
    req.wr && !soft_ff && hit(req.addr, dcr_pkg::ADDR_CHAN_SELECT) |=>
      chsel_ff == ($past(req.wdata) & dcr_pkg::MASK_CHAN_SELECT))
    else $error("channel select write not taken");

  wr_chan_a_a: assert property (
    pwr_wr && chsel_ff[1:0] == 2'h1 |=> $stable(pwr_ff[1]))
    else $error("channel B copy changed by a channel A write");

  wr_none_a: assert property (
    pwr_wr && chsel_ff[1:0] == 2'h0 |=>
      $stable(pwr_ff[0]) && $stable(pwr_ff[1]))
    else $error("local write with no channel selected changed a copy");

  rd_chan_b_a: assert property (
    pwr_rd && chsel_ff[1:0] == 2'h2 |=> rdata == $past(pwr_ff[1]))
    else $error("read with channel B selected not channel B copy");

  cfg_hold_a: assert property (
    !xfer_ff[dcr_pkg::SU_XFER] |=> $stable(cfg))
    else $error("applied configuration changed without a transfer");

  lsb_write_a: assert property (
    req.wr && !soft_ff && hit(req.addr, dcr_pkg::ADDR_PORT_SETUP) |=>
      lsb_first_ff == ($past(req.wdata[dcr_pkg::PS_LSB_HI]) ||
                       $past(req.wdata[dcr_pkg::PS_LSB_LO])))
    else $error("mirrored bit order field not taken from either copy");

endmodule

// ==== dcr_host.sv ====
module dcr_host (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // register port toward the block
  output dcr_pkg::dcr_req_type               req,
  input  wire logic [dcr_pkg::DATA_W-1:0]    rdata,
  input  wire logic                          rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // used bits per location, zero marks a fully open location
  function automatic logic [7:0] used_bits(input logic [12:0] a);
    case (a)
      13'h000: used_bits = 8'h7e;
      13'h001: used_bits = 8'hff;
      13'h002: used_bits = 8'h70;
      13'h005: used_bits = 8'h03;
      13'h008: used_bits = 8'h23;
      13'h009: used_bits = 8'h01;
      13'h0ff: used_bits = 8'h01;
      default: used_bits = 8'h00;
    endcase
  endfunction

  initial begin
    req = '0;
  end

  // one write strobe, open bits forced to zero; a fully open location gets no strobe
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    wait (rstn === 1'b1);
    if (used_bits(a) !== 8'h00) begin
      @(posedge clock);
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= d & used_bits(a);
      @(posedge clock);
      req.wr    <= 1'b0;
      // released lines flip so a stale value can never match
      req.addr  <= ~a;
      req.wdata <= ~(d & used_bits(a));
    end
  endtask

  // one read strobe, answer awaited for a bounded span
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    bit got;
    got = 1'b0;
    d = 8'hxx;
    wait (rstn === 1'b1);
    @(posedge clock);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.rd   <= 1'b0;
    req.addr <= ~a;
    #1;
    repeat (3) begin
      if (!got && rvalid === 1'b1) begin
        d = rdata;
        got = 1'b1;
      end else if (!got) begin
        @(posedge clock);
        #1;
      end
    end
  endtask
endmodule

// ==== dcr_regmap_bench.sv ====
module dcr_regmap_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] PART_ID = 8'h5a; // arbitrary value
  localparam logic [2:0] GRADE   = 3'h5;

  logic                 clock;
  logic                 rstn;
  dcr_pkg::dcr_req_type req;
  logic [7:0]           rdata;
  logic                 rvalid;
  dcr_pkg::dcr_cfg_type cfg;
  logic [7:0]           val;
  int                   miscompares;
  int                   total_checks;

  initial clock = 1'b0;
  always #5 clock = ~clock;

  dcr_regmap #(.PART_ID(PART_ID), .SPEED_GRADE(GRADE)) DUT (
    .clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
    .rvalid(rvalid), .cfg(cfg));

  dcr_host host (
    .clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
    .rvalid(rvalid));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read one location and compare
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    host.rd(a, val);
    check($sformatf("reg_%h", a), 16'(val), 16'(exp));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the roughly one hundred cycles the tests need
  initial begin
    #100000;
    miscompares++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    check("cfg", 16'(cfg), 16'h0001);
    // defaults, ids and an open location
    rd_chk(13'h000, 8'h18);
    rd_chk(13'h001, PART_ID);
    rd_chk(13'h002, {1'b0, GRADE, 4'h0});
    rd_chk(13'h005, 8'h03);
    rd_chk(13'h008, 8'h00);
    rd_chk(13'h009, 8'h01);
    rd_chk(13'h0ff, 8'h00);
    host.wr(13'h013, 8'hff);
    rd_chk(13'h013, 8'h00);
    // default select sends one write to both copies
    host.wr(13'h008, 8'h21);
    host.wr(13'h005, 8'h02);
    rd_chk(13'h008, 8'h21);
    // channel b alone, channel a keeps its copy
    host.wr(13'h008, 8'h02);
    rd_chk(13'h008, 8'h02);
    host.wr(13'h005, 8'h01);
    rd_chk(13'h008, 8'h21);
    // channel a alone, channel b keeps its copy
    host.wr(13'h008, 8'h20);
    rd_chk(13'h008, 8'h20);
    host.wr(13'h005, 8'h02);
    rd_chk(13'h008, 8'h02);
    // open bits of the select write are zeroed by the host
    host.wr(13'h005, 8'hff);
    rd_chk(13'h005, 8'h03);
    rd_chk(13'h008, 8'h20);
    // bit order through the upper mirror, applied only on transfer
    host.wr(13'h000, 8'h40);
    rd_chk(13'h000, 8'h5a);
    check("cfg", 16'(cfg), 16'h0001);
    // transfer applies both copies, settles by the third edge
    host.wr(13'h0ff, 8'h01);
    repeat (3) @(posedge clock);
    #1;
    // lsb first, a standby pin with mode 0, b mode 2, stabilizer on
    check("cfg", 16'(cfg), 16'h0099);
    rd_chk(13'h0ff, 8'h00);
    // global copy looks the same from either select
    host.wr(13'h005, 8'h01);
    host.wr(13'h009, 8'h00);
    host.wr(13'h005, 8'h02);
    rd_chk(13'h009, 8'h00);
    // no channel selected: a local write lands nowhere
    host.wr(13'h005, 8'h00);
    host.wr(13'h008, 8'h01);
    rd_chk(13'h008, 8'h00);
    host.wr(13'h005, 8'h02);
    rd_chk(13'h008, 8'h02);
    host.wr(13'h008, 8'h23);
    rd_chk(13'h008, 8'h23);
    host.wr(13'h001, 8'h00);
    rd_chk(13'h001, PART_ID);
    // soft reset through the mirrored bits reloads defaults
    host.wr(13'h000, 8'h24);
    repeat (3) @(posedge clock);
    rd_chk(13'h005, 8'h03);
    rd_chk(13'h008, 8'h00);
    rd_chk(13'h009, 8'h01);
    rd_chk(13'h000, 8'h18);
    // second hard reset in mid-run
    host.wr(13'h009, 8'h00);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    check("cfg", 16'(cfg), 16'h0001);
    rd_chk(13'h009, 8'h01);
    final_report();
  end
endmodule
